// file: verilog/rrc_cfg.svh
/*
 * Constants for the reset and remap control block: register offsets,
 * field positions, reset values and sequencer timing.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef RRC_CFG_SVH
`define RRC_CFG_SVH

// register byte addresses
`define RRC_OFF_MIRROR 32'hffff0220
`define RRC_OFF_CAUSE 32'hffff0230
`define RRC_OFF_CLEAR 32'hffff0234
`define RRC_OFF_IRQ_STAT 32'hffff0238
`define RRC_OFF_IRQ_MASK 32'hffff023c

// mirror control fields
`define RRC_MIR_SRAM_BIT 0
`define RRC_MIR_SRAM_SMALL_BIT 3
`define RRC_MIR_NVM_SMALL_BIT 4

// reset cause fields
`define RRC_CAUSE_W 3
`define RRC_CAUSE_POR_BIT 0
`define RRC_CAUSE_WDT_BIT 1
`define RRC_CAUSE_SW_BIT 2
`define RRC_CAUSE_RST 3'h1
`define RRC_CLEAR_ALL 3'h7

// interrupt status and mask fields
`define RRC_IRQ_W 4
`define RRC_IRQ_EXT_BIT 0
`define RRC_IRQ_WDT_BIT 1
`define RRC_IRQ_SW_BIT 2
`define RRC_IRQ_BOOT_BIT 3
`define RRC_IRQ_RST 4'h0

// address map
`define RRC_VEC_LO 32'h00000000
`define RRC_VEC_HI 32'h00000020
`define RRC_MIRROR_TOP 32'h00080000
`define RRC_NVM_BASE 32'h00080000
`define RRC_SRAM_BASE 32'h00010000

// sequencer timing, ns, and the clock period
`define RRC_CLK_PERIOD_NS 40
`define RRC_HOLD_NS 400
`define RRC_KERNEL_NS 2000
`define RRC_CFG_NS 4000
`define RRC_CNT_W 8

`endif

// file: verilog/rrc_pkg.sv
/*
 * Types shared by the reset and remap control block.
 * Assumes rrc_cfg.svh for widths.
 */
`include "rrc_cfg.svh"

package rrc_pkg;

	// boot sequencer states, gray along hold-kernel-config-run
	typedef enum logic [2:0] {
		RRC_ST_HOLD = 3'h0,
		RRC_ST_KERNEL = 3'h1,
		RRC_ST_CFG = 3'h3,
		RRC_ST_RUN = 3'h2,
		RRC_ST_DLOAD = 3'h6
	} rrc_state_t;

	typedef logic [`RRC_CAUSE_W-1:0] rrc_cause_t;
	typedef logic [`RRC_IRQ_W-1:0] rrc_irq_t;

endpackage

// file: verilog/rrc_reset_remap.sv
/*
 * Reset and remap control: mirror selection for the bottom of the map,
 * reset cause flags with a write-one clear, boot sequencer, interrupts.
 * Assumes one core clock, inputs synchronous to it, and a register
 * master that keeps strobes one cycle long and never both at once.
 */
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "rrc_cfg.svh"

// How it works
// RL1 - vectors 0x00 to 0x20 sit in whichever memory is mirrored at bottom
// RL2 - every reset returns the mirror to nonvolatile memory
// RL3 - writing 1 to mirror bit 0 puts SRAM at address zero
// RL4 - clearing mirror bit 0 puts nonvolatile memory back at zero
// RL5 - software switches mirror only while running above 0x00080020
// RL6 - after reset run hidden kernel, then config and vector if boot high
// RL7 - user reset handler lives in nonvolatile memory
// RL8 - four reset sources; last cause kept in cause flags
// RL9 - power-on sets cause bit 0, kept until cleared
// RL10 - watchdog reset sets cause bit 1, kept until cleared
// RL11 - writing 1 to cause bit 2 forces software reset, bit stays
// RL12 - all cause bits zero means external pin reset
// RL13 - clear register bits of 1 clear matching flags; 0x07 clears all
// RL14 - mirror bit 4 reads 1 on small nonvolatile memory variants
// RL15 - mirror bit 3 reads 1 on small SRAM variants
// RL16 - software reset drives full system reset but keeps cause flags
module rrc_reset_remap #(
	parameter bit NVM_SMALL = 1'b0,
	parameter bit SRAM_SMALL = 1'b0,
	parameter logic [31:0] MIRROR_TOP = `RRC_MIRROR_TOP,
	parameter logic [31:0] NVM_BASE = `RRC_NVM_BASE,
	parameter logic [31:0] SRAM_BASE = `RRC_SRAM_BASE
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [31:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	input wire logic i_ext_rst,
	input wire logic i_wdt_expire,
	input wire logic i_boot_mode_pin,
	input wire logic i_fetch_valid,
	input wire logic [31:0] i_fetch_addr,
	output logic [31:0] o_fetch_phys,
	output logic o_fetch_sram,
	output logic o_fetch_vector,
	output logic o_sys_rst,
	output logic o_kernel_active,
	output logic o_core_run,
	output rrc_pkg::rrc_state_t o_boot_state,
	output logic o_mirror_sram,
	output logic o_irq
);
	import rrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// timing counts, least times rounded up to whole cycles
	localparam int HOLD_CYC =
		(`RRC_HOLD_NS + `RRC_CLK_PERIOD_NS - 1) / `RRC_CLK_PERIOD_NS;
	localparam int KERNEL_CYC =
		(`RRC_KERNEL_NS + `RRC_CLK_PERIOD_NS - 1) / `RRC_CLK_PERIOD_NS;
	localparam int CFG_CYC =
		(`RRC_CFG_NS + `RRC_CLK_PERIOD_NS - 1) / `RRC_CLK_PERIOD_NS;
	localparam logic [`RRC_CNT_W-1:0] HOLD_LAST =
		`RRC_CNT_W'(HOLD_CYC - 1);
	localparam logic [`RRC_CNT_W-1:0] KERNEL_LAST =
		`RRC_CNT_W'(KERNEL_CYC - 1);
	localparam logic [`RRC_CNT_W-1:0] CFG_LAST =
		`RRC_CNT_W'(CFG_CYC - 1);
	localparam logic [`RRC_CNT_W-1:0] CNT_ZERO = `RRC_CNT_W'(0);
	localparam logic [`RRC_CNT_W-1:0] CNT_ONE = `RRC_CNT_W'(1);

	// the mirror window must cover the vectors, counts must fit
	generate
		if (MIRROR_TOP <= `RRC_VEC_HI) begin : g_bad_top
			$error("mirror window smaller than vector table");
		end
		if (HOLD_CYC < 1 || KERNEL_CYC < 1 || CFG_CYC < 1 ||
				CFG_CYC > (1 << `RRC_CNT_W) ||
				KERNEL_CYC > (1 << `RRC_CNT_W) ||
				HOLD_CYC > (1 << `RRC_CNT_W)) begin : g_bad_cnt
			$error("sequencer counts do not fit the counter");
		end
		// bases must be word aligned so vector slots stay on words
		if (NVM_BASE[1:0] != 2'h0 || SRAM_BASE[1:0] != 2'h0)
				begin : g_bad_base
			$error("memory bases must be word aligned");
		end
		// a base plus the window must not wrap past the top of the map
		if ({1'b0, NVM_BASE} + {1'b0, MIRROR_TOP} > 33'h100000000 ||
				{1'b0, SRAM_BASE} + {1'b0, MIRROR_TOP} > 33'h100000000)
				begin : g_bad_wrap
			$error("mirror window wraps past the top of the map");
		end
	endgenerate

	// register address match, shared by every decode below
	function automatic logic reg_hit(input logic [31:0] addr,
			input logic [31:0] off);
		reg_hit = (addr == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state
	rrc_state_t state_reg;
	rrc_state_t state_next;
	logic [`RRC_CNT_W-1:0] cnt_reg;
	logic [`RRC_CNT_W-1:0] cnt_next;
	logic mirror_reg;
	logic mirror_next;
	rrc_cause_t cause_reg;
	rrc_irq_t irq_stat_reg;
	rrc_irq_t irq_stat_next;
	rrc_irq_t irq_mask_reg;
	rrc_irq_t irq_mask_next;
	logic ext_seen_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] phys_reg;
	logic [31:0] phys_next;
	logic fetch_sram_reg;
	logic fetch_sram_next;
	logic fetch_vec_reg;
	logic fetch_vec_next;

	////////////////////////////////////////////////////////////////////////
	// register bus decode
	wire wr_mirror = i_reg_wr && reg_hit(i_reg_addr, `RRC_OFF_MIRROR);
	wire wr_cause = i_reg_wr && reg_hit(i_reg_addr, `RRC_OFF_CAUSE);
	wire wr_clear = i_reg_wr && reg_hit(i_reg_addr, `RRC_OFF_CLEAR);
	wire wr_mask = i_reg_wr && reg_hit(i_reg_addr, `RRC_OFF_IRQ_MASK);
	wire rd_stat = i_reg_rd && reg_hit(i_reg_addr, `RRC_OFF_IRQ_STAT);

	// reset sources; the software one is a write of 1 to cause bit 2
	wire sw_force = wr_cause &&
		i_reg_wdata[`RRC_CAUSE_SW_BIT]; // RL11
	wire ext_rise = i_ext_rst && !ext_seen_reg;
	wire any_rst = i_ext_rst || i_wdt_expire || sw_force; // RL8 RL16
	// an external reset alone leaves the flags empty
	wire ext_only = i_ext_rst && !i_wdt_expire && !sw_force;

	////////////////////////////////////////////////////////////////////////
	// reset cause flags, one generate slice per bit
	// the power-on bit has no set term here: only the synchronous
	// reset loads it, through the reset value of the slice below
	rrc_cause_t cause_set;
	rrc_cause_t cause_clr;
	assign cause_set[`RRC_CAUSE_POR_BIT] = 1'b0; // set only by i_srst
	assign cause_set[`RRC_CAUSE_WDT_BIT] = i_wdt_expire; // RL10
	assign cause_set[`RRC_CAUSE_SW_BIT] = sw_force; // RL11
	// write-one clear; external-only reset empties the record
	assign cause_clr = (wr_clear ? i_reg_wdata[`RRC_CAUSE_W-1:0] :
		{`RRC_CAUSE_W{1'b0}}) | {`RRC_CAUSE_W{ext_only}}; // RL13 RL12

	genvar gi;
	generate
		for (gi = 0; gi < `RRC_CAUSE_W; gi++) begin : g_cause
			localparam rrc_cause_t RST_V = `RRC_CAUSE_RST;
			// set beats clear in the same cycle, so no cause is lost
			wire bit_next = cause_set[gi] ||
				(cause_reg[gi] && !cause_clr[gi]);
			always_ff @(posedge i_core_clk) begin
				if (i_srst) begin
					cause_reg[gi] <= RST_V[gi]; // RL9
				end else begin
					cause_reg[gi] <= bit_next; // RL10 RL11 RL13
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// mirror selection; any reset restores nonvolatile memory at zero
	assign mirror_next = (any_rst || state_reg == RRC_ST_HOLD) ? 1'b0 :
		wr_mirror ? i_reg_wdata[`RRC_MIR_SRAM_BIT] : // RL3 RL4
		mirror_reg; // RL2 RL16

	////////////////////////////////////////////////////////////////////////
	// boot sequencer: hold, hidden kernel, config, then core runs
	wire hold_done = (cnt_reg == CNT_ZERO) && !i_ext_rst;
	wire kern_done = (cnt_reg == CNT_ZERO);
	wire cfg_done = (cnt_reg == CNT_ZERO);

	// any reset source wins over the case below and reloads the hold
	// count, so a source during kernel or config restarts the whole
	// sequence; the parked download state is left only by a reset
	// source, and the kernel flag stays up there so the core stays off
	always_comb begin
		state_next = state_reg;
		cnt_next = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - CNT_ONE;
		if (any_rst) begin
			state_next = RRC_ST_HOLD; // RL16
			cnt_next = HOLD_LAST;
		end else begin
			unique case (state_reg)
				RRC_ST_HOLD: begin
					if (hold_done) begin
						state_next = RRC_ST_KERNEL; // RL6
						cnt_next = KERNEL_LAST;
					end
				end
				RRC_ST_KERNEL: begin
					if (kern_done) begin
						// boot pin low keeps the core parked
						state_next = i_boot_mode_pin ? RRC_ST_CFG :
							RRC_ST_DLOAD; // RL6
						cnt_next = CFG_LAST;
					end
				end
				RRC_ST_CFG: begin
					if (cfg_done) begin
						state_next = RRC_ST_RUN; // RL6
					end
				end
				RRC_ST_RUN: begin
					state_next = RRC_ST_RUN;
				end
				RRC_ST_DLOAD: begin
					state_next = RRC_ST_DLOAD;
				end
				default: begin
					state_next = RRC_ST_HOLD;
					cnt_next = HOLD_LAST;
				end
			endcase
		end
	end

	// the core starts at vector zero when the run state is entered
	wire boot_done = (state_reg == RRC_ST_CFG) && cfg_done &&
		!any_rst; // RL6

	////////////////////////////////////////////////////////////////////////
	// interrupt status: sticky, read clears, new event beats the clear
	// a read of the status clears it, but an event in that same
	// cycle is kept, so no event is lost between read and clear
	rrc_irq_t irq_evt;
	assign irq_evt[`RRC_IRQ_EXT_BIT] = ext_rise;
	assign irq_evt[`RRC_IRQ_WDT_BIT] = i_wdt_expire;
	assign irq_evt[`RRC_IRQ_SW_BIT] = sw_force;
	assign irq_evt[`RRC_IRQ_BOOT_BIT] = boot_done;
	assign irq_stat_next = irq_evt |
		(rd_stat ? {`RRC_IRQ_W{1'b0}} : irq_stat_reg);
	assign irq_mask_next = wr_mask ? i_reg_wdata[`RRC_IRQ_W-1:0] :
		irq_mask_reg;

	////////////////////////////////////////////////////////////////////////
	// read data; reserved bits, the clear register and holes read zero
	// read data is zero outside the cycle after a read strobe, so a
	// bus that ors several slaves' data needs no extra select here;
	// the clear register is write only and reads back as zero
	wire [7:0] mirror_rd = {3'h0, NVM_SMALL, SRAM_SMALL, 2'h0,
		mirror_reg}; // RL14 RL15
	wire [31:0] rd_mux =
		reg_hit(i_reg_addr, `RRC_OFF_MIRROR) ? {24'h0, mirror_rd} :
		reg_hit(i_reg_addr, `RRC_OFF_CAUSE) ?
			{29'h0, cause_reg} : // RL8 RL12
		reg_hit(i_reg_addr, `RRC_OFF_IRQ_STAT) ? {28'h0, irq_stat_reg} :
		reg_hit(i_reg_addr, `RRC_OFF_IRQ_MASK) ? {28'h0, irq_mask_reg} :
		32'h0;
	assign rdata_next = i_reg_rd ? rd_mux : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// fetch path: bottom window goes to whichever memory is mirrored
	// the mirror flop is read, not its next value: a write to the
	// control register takes effect on the fetch after the write edge.
	// code switching the mirror must run above the window, since the
	// bottom region changes under it in that very cycle
	wire in_window = (i_fetch_addr < MIRROR_TOP);
	wire is_vector = (i_fetch_addr >= `RRC_VEC_LO) &&
		(i_fetch_addr <= `RRC_VEC_HI); // RL1
	wire [31:0] win_base = mirror_reg ? SRAM_BASE : NVM_BASE;
	// sum cut to the address width on purpose; the wrap check above
	// keeps the carry from ever being needed
	wire [31:0] win_phys = 32'(win_base + i_fetch_addr);
	// vectors follow the window, so the handler memory decides
	assign phys_next = !i_fetch_valid ? 32'h0 :
		in_window ? win_phys : i_fetch_addr; // RL1 RL7
	assign fetch_sram_next = i_fetch_valid && in_window &&
		mirror_reg; // RL3 RL5
	assign fetch_vec_next = i_fetch_valid && is_vector; // RL1

	////////////////////////////////////////////////////////////////////////
	// sequencer and mirror flops
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_reg <= RRC_ST_HOLD;
			cnt_reg <= HOLD_LAST;
			mirror_reg <= 1'b0; // RL2
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			mirror_reg <= mirror_next;
		end
	end

	// interrupt, edge tracking and read data flops
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			irq_stat_reg <= `RRC_IRQ_RST;
			irq_mask_reg <= `RRC_IRQ_RST;
			ext_seen_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			ext_seen_reg <= i_ext_rst;
			rdata_reg <= rdata_next;
		end
	end

	// fetch decode flops, one cycle of latency for timing
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			phys_reg <= 32'h0;
			fetch_sram_reg <= 1'b0;
			fetch_vec_reg <= 1'b0;
		end else begin
			phys_reg <= phys_next;
			fetch_sram_reg <= fetch_sram_next;
			fetch_vec_reg <= fetch_vec_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_reg_rdata = rdata_reg;
	assign o_fetch_phys = phys_reg;
	assign o_fetch_sram = fetch_sram_reg;
	assign o_fetch_vector = fetch_vec_reg;
	assign o_sys_rst = (state_reg == RRC_ST_HOLD); // RL16
	assign o_kernel_active = (state_reg == RRC_ST_KERNEL) ||
		(state_reg == RRC_ST_DLOAD); // RL6
	assign o_core_run = (state_reg == RRC_ST_RUN); // RL6
	assign o_boot_state = state_reg;
	assign o_mirror_sram = mirror_reg;
	// level interrupt while any unmasked event is pending
	assign o_irq = |(irq_stat_reg & irq_mask_reg);

endmodule // rrc_reset_remap

// file: sim/rrc_cpu_model.sv
/* Processor fetch path model: fetches while the core runs.
 * Assumes the core clock and the run flag of the block. */
`timescale 1ns/10ps
module rrc_cpu_model (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_run,
	input wire logic i_hi,
	output logic o_fv,
	output logic [31:0] o_fa
);
	// idle address toggles so a stale value never looks valid
	always_ff @(posedge i_core_clk) begin
		o_fv <= i_run & ~i_srst;
		if (i_srst)
			o_fa <= 32'h0;
		else if (!i_run)
			o_fa <= ~o_fa;
		else if (!o_fv)
			o_fa <= 32'h0;
		else if (i_hi)
			o_fa <= 32'h00080024;
		else
			o_fa <= (o_fa + 32'h4) & 32'h3c;
	end
endmodule // rrc_cpu_model

// file: sim/rrc_reset_remap_monitor.sv
/* Checker for the reset and remap block, bound to its top.
 * Assumes one core clock and a synchronous reset. */
`timescale 1ns/10ps
`include "rrc_cfg.svh"
module rrc_reset_remap_monitor #(
	parameter logic [31:0] MIRROR_TOP = 32'h0,
	parameter logic [31:0] NVM_BASE = 32'h0,
	parameter logic [31:0] SRAM_BASE = 32'h0
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [31:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic i_ext_rst,
	input wire logic i_wdt_expire,
	input wire logic i_boot_mode_pin,
	input wire logic i_fetch_valid,
	input wire logic [31:0] i_fetch_addr,
	input wire logic [31:0] o_fetch_phys,
	input wire logic o_fetch_sram,
	input wire logic o_fetch_vector,
	input wire logic o_sys_rst,
	input wire logic o_kernel_active,
	input wire logic o_core_run,
	input wire rrc_pkg::rrc_state_t o_boot_state,
	input wire logic o_mirror_sram,
	input wire logic o_irq
);
	import rrc_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	////////////////////
	// read data only in the cycle after a read strobe
	property p_rd_idle;
		!$past(i_reg_rd) |-> o_reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without read");
	property p_mirror_wr;
		i_reg_wr && i_reg_addr == `RRC_OFF_MIRROR && !o_sys_rst
			&& !i_wdt_expire && !i_ext_rst
			|=> o_mirror_sram == $past(i_reg_wdata[0]);
	endproperty
	a_mirror_wr: assert property (p_mirror_wr)
		else $error("mirror bit not written");
	property p_wdt;
		i_wdt_expire |=> o_sys_rst && !o_mirror_sram;
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog did not reset");
	property p_hold;
		i_wdt_expire && !o_sys_rst |=> o_sys_rst [*8];
	endproperty
	a_hold: assert property (p_hold)
		else $error("reset hold too short");
	property p_boot;
		$fell(o_kernel_active) && !o_sys_rst
			|-> $past(i_boot_mode_pin) && o_boot_state == RRC_ST_CFG;
	endproperty
	a_boot: assert property (p_boot)
		else $error("kernel exit wrong");
	property p_run;
		$rose(o_core_run) |-> $past(o_boot_state) == RRC_ST_CFG;
	endproperty
	a_run: assert property (p_run)
		else $error("run without config");
	// translation uses the mirror state seen with the request
	property p_fetch_sram;
		i_fetch_valid && i_fetch_addr < MIRROR_TOP && o_mirror_sram
			|=> o_fetch_sram
			&& o_fetch_phys == SRAM_BASE + $past(i_fetch_addr);
	endproperty
	a_fetch_sram: assert property (p_fetch_sram)
		else $error("bottom fetch not in sram");
	property p_fetch_nvm;
		i_fetch_valid && i_fetch_addr < MIRROR_TOP && !o_mirror_sram
			|=> !o_fetch_sram
			&& o_fetch_phys == NVM_BASE + $past(i_fetch_addr);
	endproperty
	a_fetch_nvm: assert property (p_fetch_nvm)
		else $error("bottom fetch not in nvm");
	property p_vec;
		i_fetch_valid && i_fetch_addr <= `RRC_VEC_HI |=> o_fetch_vector;
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector fetch not flagged");
	c_sram: cover property (o_fetch_sram);
	c_run: cover property ($rose(o_core_run));
	c_irq: cover property (o_irq);
endmodule // rrc_reset_remap_monitor

bind rrc_reset_remap rrc_reset_remap_monitor #(
	.MIRROR_TOP(MIRROR_TOP),
	.NVM_BASE(NVM_BASE),
	.SRAM_BASE(SRAM_BASE)
) u_mon (.*);

// file: sim/reset_remap_control_test.sv
/* Self-checking bench for the reset and remap block.
 * Assumes the design, fetch model and checker are compiled first. */
`timescale 1ns/10ps
`include "rrc_cfg.svh"
module reset_remap_control_test;
	logic clk, srst, wr, rd, ext, wdt, boot, fv, hi, rd_d, irq, run;
	logic [31:0] addr, wdata, fa, rdata, rnd;
	int fails, comparisons, cyc;
	logic [31:0] q[$];
	////////////////////
	rrc_reset_remap #(.NVM_SMALL(1'b1), .SRAM_SMALL(1'b1)) uut (
		.i_core_clk(clk), .i_srst(srst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_ext_rst(ext), .i_wdt_expire(wdt),
		.i_boot_mode_pin(boot), .i_fetch_valid(fv), .i_fetch_addr(fa),
		.o_fetch_phys(), .o_fetch_sram(), .o_fetch_vector(),
		.o_sys_rst(), .o_kernel_active(), .o_core_run(run),
		.o_boot_state(), .o_mirror_sram(), .o_irq(irq));
	rrc_cpu_model u_cpu (.i_core_clk(clk), .i_srst(srst), .i_run(run),
		.i_hi(hi), .o_fv(fv), .o_fa(fa));
	////////////////////
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// expected read value is noted when the read goes out
	task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic wait_run;
		int n;
		n = 0;
		repeat (3) @(posedge clk);
		while (run !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, run}, 32'h1);
	endtask
	task automatic final_report;
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////
	// clock; watcher compares settled read data off the edge
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) if (rd_d) check(rdata, q.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		srst = 1'b1;
		{wr, rd, ext, wdt, hi} = 5'h0;
		boot = 1'b1;
		addr = 32'h0;
		wdata = 32'h0;
		rnd = 32'd75333;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd_reg(`RRC_OFF_MIRROR, 32'h18);
		rd_reg(`RRC_OFF_CAUSE, 32'h1);
		rd_reg(`RRC_OFF_CLEAR, 32'h0);
		rd_reg(32'hffff0240, 32'h0);
		wait_run();
		check({31'h0, irq}, 32'h0);
		rd_reg(`RRC_OFF_IRQ_STAT, 32'h8);
		wr_reg(`RRC_OFF_IRQ_MASK, 32'h2);
		// mirror both ways, switched from code above the window
		for (int b = 1; b >= 0; b--) begin
			rnd = xs(rnd);
			hi <= 1'b1;
			wr_reg(`RRC_OFF_MIRROR, {rnd[31:1], b[0]});
			rd_reg(`RRC_OFF_MIRROR, 32'h18 | b);
			hi <= 1'b0;
			repeat (20) @(posedge clk);
		end
		wr_reg(`RRC_OFF_MIRROR, 32'h1);
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		wait_run();
		check({31'h0, irq}, 32'h1);
		rd_reg(`RRC_OFF_MIRROR, 32'h18);
		rd_reg(`RRC_OFF_CAUSE, 32'h3);
		rd_reg(`RRC_OFF_IRQ_STAT, 32'ha);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr_reg(`RRC_OFF_MIRROR, 32'h1);
		wr_reg(`RRC_OFF_CAUSE, 32'h4);
		wait_run();
		rd_reg(`RRC_OFF_MIRROR, 32'h18);
		rd_reg(`RRC_OFF_CAUSE, 32'h7);
		wr_reg(`RRC_OFF_CLEAR, 32'h2);
		rd_reg(`RRC_OFF_CAUSE, 32'h5);
		@(posedge clk);
		ext <= 1'b1;
		repeat (3) @(posedge clk);
		ext <= 1'b0;
		wait_run();
		rd_reg(`RRC_OFF_CAUSE, 32'h0);
		// boot pin low: the core must stay parked after the kernel
		boot <= 1'b0;
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		repeat (250) @(posedge clk);
		check({31'h0, run}, 32'h0);
		boot <= 1'b1;
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		wait_run();
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd_reg(`RRC_OFF_CAUSE, 32'h1);
		wr_reg(`RRC_OFF_CLEAR, `RRC_CLEAR_ALL);
		rd_reg(`RRC_OFF_CAUSE, 32'h0);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule // reset_remap_control_test
